//--- onwc_pkg.sv
// Package for the OTP nibble write command handler
package onwc_pkg;

  // ---------------------------------------------------------------
  // Command frame fields
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_NIBBLE_WRITE = 4'h9;
  localparam logic [3:0] GLOBAL_ADDR      = 4'h0;
  localparam int         FRM_CMD_LSB      = 0;
  localparam int         FRM_ADR_LSB      = 4;
  localparam int         FRM_VAL_LSB      = 8;
  localparam int         FRM_TGT_LSB      = 12;

  // ---------------------------------------------------------------
  // Frame formats
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    FMT_STD_LONG,
    FMT_STD_SHORT,
    FMT_ENH_LONG,
    FMT_ENH_SHORT
  } onwc_fmt_t;

  // ---------------------------------------------------------------
  // Nibble targets
  // ---------------------------------------------------------------
  localparam logic [3:0] TGT_LOCK   = 4'h7;
  localparam logic [3:0] TGT_FILTER = 4'h8;
  localparam logic [3:0] TGT_IDSEL  = 4'hA;
  localparam logic [3:0] TGT_ADDR   = 4'h7;
  localparam logic [1:0] BANK_ZERO  = 2'h0;
  localparam logic [1:0] BANK_ONE   = 2'h1;

  // ---------------------------------------------------------------
  // Register field positions
  // ---------------------------------------------------------------
  localparam int LOCK_BIT      = 7;
  localparam int FILTER_LSB    = 6;
  localparam int IDSEL_BIT     = 7;
  localparam int ADDR_LSB      = 0;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h01;
  localparam logic [7:0] OPTS_RST = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ         = 125;
  localparam int BURN_TIME_US    = 100;
  localparam int BURN_BIT_CYCLES = BURN_TIME_US * CLK_MHZ;

  // ---------------------------------------------------------------
  // Handler states
  // ---------------------------------------------------------------
  typedef enum logic [1:0]
  {
    ST_IDLE,
    ST_BURN,
    ST_REPLY
  } onwc_state_t;

endpackage : onwc_pkg

//--- onwc_burn_if.sv
// Interface between the command handler and the burn timer
`timescale 1ns/10ps
interface onwc_burn_if;
  logic       start;
  logic [2:0] bits;
  logic       done;

  modport ctrl
  (
    output start,
    output bits,
    input  done
  );
  modport timer
  (
    input  start,
    input  bits,
    output done
  );
endinterface : onwc_burn_if

//--- onwc_burn_timer.sv
// Burn timer: per-bit time times number of bits burned
`timescale 1ns/10ps
module onwc_burn_timer
  import onwc_pkg::*;
#(
  parameter int BIT_CYCLES = onwc_pkg::BURN_BIT_CYCLES
)
(
  input  wire logic MCLK,
  input  wire logic RST,
  onwc_burn_if.timer bif
);
  logic [2:0]  bits_q;
  logic [31:0] cnt_q;
  logic        busy_q;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      busy_q   <= 1'b0;
      bits_q   <= 3'h0;
      cnt_q    <= 32'h0;
      bif.done <= 1'b0;
    end
    else
    begin
      bif.done <= 1'b0;
      if (bif.start)
      begin
        busy_q <= (bif.bits != 3'h0);
        bits_q <= bif.bits;
        cnt_q  <= 32'(BIT_CYCLES - 1);
        bif.done <= (bif.bits == 3'h0);
      end
      else if (busy_q)
      begin
        if (cnt_q != 32'h0)
          cnt_q <= cnt_q - 32'h1;
        else if (bits_q > 3'h1)
        begin
          bits_q <= bits_q - 3'h1;
          cnt_q  <= 32'(BIT_CYCLES - 1);
        end
        else
        begin
          busy_q   <= 1'b0;
          bif.done <= 1'b1;
        end
      end
    end
  end
endmodule : onwc_burn_timer

//--- onwc_top.sv
// OTP nibble write command handler with response builder
`timescale 1ns/10ps

// Summary of operation
// RULE_01: Act only on standard long or enhanced long frames; drop others.
// RULE_02: Ignore the command when the frame carries global address zero.
// RULE_03: Command code 1001 identifies the nibble write.
// RULE_04: Data bits 7-4 are nibble target, bits 3-0 the value.
// RULE_05: Ignore unless the address field equals the programmed address.
// RULE_06: Enabled reply: address, target, 11, bank, register nibble.
// RULE_07: Reply nibble is register content read after the write.
// RULE_08: Reply bank bits are the bank from the last initialization.
// RULE_09: Burn OTP only with enable flag set; else mirror only.
// RULE_10: Disabled reply: address, 0000, 1111, address again.
// RULE_11: When the address changes, the reply carries the new address.
// RULE_12: Burn time equals per-bit time times bits programmed.
// RULE_13: Master leaves idle time covering the full burn duration.
// RULE_14: Master should read registers back to confirm contents.
// RULE_15: Every write updates mirrors and the integrity calculation.
// RULE_16: Integrity mismatch is flagged only while the lock bit is set.
// RULE_17: Unused targets: no write, reply nibble is device address.
// RULE_18: Bank 0 target 0111: bit 3 writes the lock bit.
// RULE_19: Bank 0 target 1000: bits 3-2 write filter select.
// RULE_20: Bank 0 target 1010: bit 3 writes identity select bit.
// RULE_21: Bank 1 target 0111: all four bits write the bus address.
// RULE_22: Unassigned targets behave as unused entries.
// RULE_23: Frames failing CRC are discarded with no write or reply.
module onwc_top
  import onwc_pkg::*;
#(
  parameter int BIT_CYCLES = onwc_pkg::BURN_BIT_CYCLES
)
(
  input  wire logic             MCLK,
  input  wire logic             RST,
  input  wire logic             FRAME_VALID,
  input  wire logic [15:0]      FRAME_DATA,
  input  wire onwc_pkg::onwc_fmt_t FRAME_FMT,
  input  wire logic             FRAME_CRC_OK,
  input  wire logic             PROGRAM_ENABLE_FLAG,
  input  wire logic [1:0]       BANK_SEL,
  input  wire logic [7:0]       CRC_STORED,
  output logic                  RESP_VALID,
  output logic [15:0]           RESP_DATA,
  output logic                  BUSY,
  output logic                  BURN_EN,
  output logic [3:0]            BURN_TARGET,
  output logic [3:0]            BURN_MASK,
  output logic [3:0]            BURN_VALUE,
  output logic [7:0]            CONFIG_ONE_REGISTER,
  output logic [7:0]            CONFIG_TWO_REGISTER,
  output logic [7:0]            SENSOR_OPTIONS_REGISTER,
  output logic                  INTEGRITY_ERROR
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] target_mask(input logic [1:0] bank,
                                             input logic [3:0] tgt);
    target_mask = 4'h0;
    if (bank == BANK_ZERO)
    begin
      case (tgt)
        TGT_LOCK:   target_mask = 4'h8; // [RULE_18]
        TGT_FILTER: target_mask = 4'hC; // [RULE_19]
        TGT_IDSEL:  target_mask = 4'h8; // [RULE_20]
        default:    target_mask = 4'h0; // [RULE_22]
      endcase
    end
    else if (bank == BANK_ONE && tgt == TGT_ADDR)
      target_mask = 4'hF;               // [RULE_21]
  endfunction : target_mask

  function automatic logic [2:0] ones(input logic [3:0] v);
    ones = 3'({2'h0, v[0]} + {2'h0, v[1]} + {2'h0, v[2]} + {2'h0, v[3]});
  endfunction : ones

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic [3:0] f_cmd;
  logic [3:0] f_adr;
  logic [3:0] f_val;
  logic [3:0] f_tgt;
  logic       fmt_ok;
  logic       accept;
  logic [3:0] dev_addr;

  assign f_cmd  = FRAME_DATA[FRM_CMD_LSB +: 4];
  assign f_adr  = FRAME_DATA[FRM_ADR_LSB +: 4];
  assign f_val  = FRAME_DATA[FRM_VAL_LSB +: 4];
  assign f_tgt  = FRAME_DATA[FRM_TGT_LSB +: 4];
  assign fmt_ok = (FRAME_FMT == FMT_STD_LONG)
               || (FRAME_FMT == FMT_ENH_LONG);          // [RULE_01]
  assign dev_addr = CONFIG_TWO_REGISTER[ADDR_LSB +: 4]; // [RULE_11]

  onwc_state_t state_q;

  assign accept = FRAME_VALID && (state_q == ST_IDLE)
               && FRAME_CRC_OK                          // [RULE_23]
               && fmt_ok
               && (f_cmd == CMD_NIBBLE_WRITE)           // [RULE_03]
               && (f_adr != GLOBAL_ADDR)                // [RULE_02]
               && (f_adr == dev_addr);                  // [RULE_05]

  // ---------------------------------------------------------------
  // Captured command
  // ---------------------------------------------------------------
  logic [3:0] tgt_q;
  logic [3:0] val_q;
  logic [3:0] mask_q;
  logic [1:0] bank_q;
  logic       prog_q;

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      tgt_q  <= 4'h0;
      val_q  <= 4'h0;
      mask_q <= 4'h0;
      bank_q <= 2'h0;
      prog_q <= 1'b0;
    end
    else if (accept)
    begin
      tgt_q  <= f_tgt;                                  // [RULE_04]
      val_q  <= f_val;
      mask_q <= target_mask(BANK_SEL, f_tgt);
      bank_q <= BANK_SEL;                               // [RULE_08]
      prog_q <= PROGRAM_ENABLE_FLAG;
    end
  end

  // ---------------------------------------------------------------
  // Burn timer
  // ---------------------------------------------------------------
  onwc_burn_if bif ();
  logic [3:0] burn_bits;

  assign burn_bits  = target_mask(BANK_SEL, f_tgt) & f_val;
  assign bif.start  = accept && PROGRAM_ENABLE_FLAG;    // [RULE_09]
  assign bif.bits   = ones(burn_bits);                  // [RULE_12]

  onwc_burn_timer #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_timer (
    .MCLK (MCLK),
    .RST  (RST),
    .bif  (bif)
  );

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RST)
      state_q <= ST_IDLE;
    else
    begin
      case (state_q)
        ST_IDLE:
          if (accept)
            state_q <= PROGRAM_ENABLE_FLAG ? ST_BURN : ST_REPLY;
        ST_BURN:
          if (bif.done)
            state_q <= ST_REPLY;
        ST_REPLY:
          state_q <= ST_IDLE;
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (RST)
      BUSY <= 1'b0;
    else
      BUSY <= accept || (state_q == ST_BURN)
           || (BUSY && state_q != ST_REPLY);
  end

  // ---------------------------------------------------------------
  // OTP burn strobes
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      BURN_EN     <= 1'b0;
      BURN_TARGET <= 4'h0;
      BURN_MASK   <= 4'h0;
      BURN_VALUE  <= 4'h0;
    end
    else
    begin
      BURN_EN <= bif.start && (burn_bits != 4'h0);      // [RULE_09]
      if (bif.start)
      begin
        BURN_TARGET <= f_tgt;
        BURN_MASK   <= burn_bits;
        BURN_VALUE  <= f_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // Mirror registers
  // ---------------------------------------------------------------
  logic [3:0] m;

  assign m = target_mask(BANK_SEL, f_tgt);

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      CONFIG_ONE_REGISTER     <= CFG1_RST;
      CONFIG_TWO_REGISTER     <= CFG2_RST;
      SENSOR_OPTIONS_REGISTER <= OPTS_RST;
    end
    else if (accept && m != 4'h0)                       // [RULE_15]
    begin
      if (BANK_SEL == BANK_ZERO && f_tgt == TGT_LOCK)
        CONFIG_TWO_REGISTER[LOCK_BIT] <= f_val[3];      // [RULE_18]
      if (BANK_SEL == BANK_ZERO && f_tgt == TGT_FILTER)
        SENSOR_OPTIONS_REGISTER[FILTER_LSB +: 2]
          <= f_val[3:2];                                // [RULE_19]
      if (BANK_SEL == BANK_ZERO && f_tgt == TGT_IDSEL)
        CONFIG_ONE_REGISTER[IDSEL_BIT] <= f_val[3];     // [RULE_20]
      if (BANK_SEL == BANK_ONE && f_tgt == TGT_ADDR)
        CONFIG_TWO_REGISTER[ADDR_LSB +: 4] <= f_val;    // [RULE_21]
    end
  end

  // ---------------------------------------------------------------
  // Integrity check
  // ---------------------------------------------------------------
  logic [7:0] sum;

  assign sum = CONFIG_ONE_REGISTER ^ CONFIG_TWO_REGISTER
             ^ SENSOR_OPTIONS_REGISTER;                 // [RULE_15]

  always_ff @(posedge MCLK)
  begin
    if (RST)
      INTEGRITY_ERROR <= 1'b0;
    else
      INTEGRITY_ERROR <= CONFIG_TWO_REGISTER[LOCK_BIT]
                      && (sum != CRC_STORED);           // [RULE_16]
  end

  // ---------------------------------------------------------------
  // Response builder
  // ---------------------------------------------------------------
  function automatic logic [3:0] read_back(input logic [1:0] bank,
                                           input logic [3:0] tgt,
                                           input logic [7:0] c1,
                                           input logic [7:0] c2,
                                           input logic [7:0] op);
    read_back = c2[ADDR_LSB +: 4];                      // [RULE_17]
    if (bank == BANK_ZERO && tgt == TGT_LOCK)
      read_back = c2[7:4];
    else if (bank == BANK_ZERO && tgt == TGT_FILTER)
      read_back = op[7:4];
    else if (bank == BANK_ZERO && tgt == TGT_IDSEL)
      read_back = c1[7:4];
    else if (bank == BANK_ONE && tgt == TGT_ADDR)
      read_back = c2[3:0];
  endfunction : read_back

  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      RESP_VALID <= 1'b0;
      RESP_DATA  <= 16'h0000;
    end
    else
    begin
      RESP_VALID <= (state_q == ST_REPLY);
      if (state_q == ST_REPLY)
      begin
        if (prog_q)
          RESP_DATA <= {dev_addr, tgt_q, 2'h3, bank_q,  // [RULE_06]
                        read_back(bank_q, tgt_q,        // [RULE_07]
                                  CONFIG_ONE_REGISTER,
                                  CONFIG_TWO_REGISTER,
                                  SENSOR_OPTIONS_REGISTER)};
        else
          RESP_DATA <= {dev_addr, 4'h0, 4'hF, dev_addr}; // [RULE_10]
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  chk_bad_format: assert property ( // [RULE_01]
    @(posedge MCLK) disable iff (RST)
    (FRAME_VALID && !fmt_ok) |-> !accept)
    else $error("short frame accepted");

  chk_global_addr: assert property ( // [RULE_02]
    @(posedge MCLK) disable iff (RST)
    (FRAME_VALID && f_adr == GLOBAL_ADDR) |-> !accept)
    else $error("global address accepted");

  chk_disabled_reply: assert property ( // [RULE_10]
    @(posedge MCLK) disable iff (RST)
    (accept && !PROGRAM_ENABLE_FLAG) |-> ##2
      (RESP_VALID && RESP_DATA[11:4] == 8'h0F))
    else $error("disabled reply wrong");

  chk_enabled_mark: assert property ( // [RULE_06]
    @(posedge MCLK) disable iff (RST)
    (RESP_VALID && prog_q) |-> RESP_DATA[7:6] == 2'h3)
    else $error("enabled reply marker wrong");

  chk_crc_drop: assert property ( // [RULE_23]
    @(posedge MCLK) disable iff (RST)
    (FRAME_VALID && !FRAME_CRC_OK) |=> !BURN_EN)
    else $error("burn on bad crc");

  chk_lock_mismatch: assert property ( // [RULE_16]
    @(posedge MCLK) disable iff (RST)
    INTEGRITY_ERROR |-> $past(CONFIG_TWO_REGISTER[LOCK_BIT]))
    else $error("mismatch without lock");

  chk_burn_gate: assert property ( // [RULE_09]
    @(posedge MCLK) disable iff (RST)
    (accept && !PROGRAM_ENABLE_FLAG) |=> !BURN_EN)
    else $error("burn with enable clear");

  chk_addr_change: assert property ( // [RULE_11]
    @(posedge MCLK) disable iff (RST)
    RESP_VALID |-> RESP_DATA[15:12] == dev_addr)
    else $error("reply address is not the current one");

  chk_addr_write: assert property ( // [RULE_21]
    @(posedge MCLK) disable iff (RST)
    (accept && BANK_SEL == BANK_ONE && f_tgt == TGT_ADDR)
      |=> dev_addr == $past(f_val))
    else $error("address field not written");

endmodule : onwc_top

//--- onwc_master_model.sv
// Bus master model that frames write commands towards the handler
`timescale 1ns/10ps
module onwc_master_model
(
  input  wire logic          MCLK,
  output logic               FRAME_VALID,
  output logic [15:0]        FRAME_DATA,
  output onwc_pkg::onwc_fmt_t FRAME_FMT,
  output logic               FRAME_CRC_OK
);
  import onwc_pkg::*;

  initial
  begin
    FRAME_VALID  = 1'b0;
    FRAME_DATA   = 16'h0000;
    FRAME_FMT    = FMT_STD_LONG;
    FRAME_CRC_OK = 1'b0;
  end

  // One frame, after an idle gap; slow masters use a longer gap
  task automatic send(input onwc_fmt_t fmt, input logic crc_ok,
                      input logic [15:0] data, input int gap);
    repeat (gap) @(posedge MCLK);
    @(posedge MCLK);
    #1;
    FRAME_VALID  = 1'b1;
    FRAME_FMT    = fmt;
    FRAME_CRC_OK = crc_ok;
    FRAME_DATA   = data;
    @(posedge MCLK);
    #1;
    FRAME_VALID  = 1'b0;
    FRAME_CRC_OK = ~crc_ok;
    FRAME_FMT    = onwc_fmt_t'(~fmt);
    FRAME_DATA   = ~data;
  endtask : send
endmodule : onwc_master_model

//--- otp_nibble_write_cmd_tb.sv
// Self-checking bench for the nibble write command handler
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module otp_nibble_write_cmd_tb;
  import onwc_pkg::*;
  localparam int BITC = 4;

  logic        mclk, rst, frame_valid, frame_crc_ok, prog_en;
  logic [15:0] frame_data, resp_data;
  onwc_fmt_t   frame_fmt;
  logic [1:0]  bank_sel;
  logic [7:0]  crc_stored, cfg1, cfg2, opts, e_c1, e_c2, e_op;
  logic        resp_valid, busy, burn_en, integ_err;
  logic [3:0]  burn_target, burn_mask, burn_value, b_tgt, b_msk, b_val;
  int          errors, total_checks, burns;

  onwc_master_model u_master
  (
    .MCLK         (mclk),
    .FRAME_VALID  (frame_valid),
    .FRAME_DATA   (frame_data),
    .FRAME_FMT    (frame_fmt),
    .FRAME_CRC_OK (frame_crc_ok)
  );

  onwc_top #(.BIT_CYCLES(BITC)) DUT
  (
    .MCLK                    (mclk),
    .RST                     (rst),
    .FRAME_VALID             (frame_valid),
    .FRAME_DATA              (frame_data),
    .FRAME_FMT               (frame_fmt),
    .FRAME_CRC_OK            (frame_crc_ok),
    .PROGRAM_ENABLE_FLAG     (prog_en),
    .BANK_SEL                (bank_sel),
    .CRC_STORED              (crc_stored),
    .RESP_VALID              (resp_valid),
    .RESP_DATA               (resp_data),
    .BUSY                    (busy),
    .BURN_EN                 (burn_en),
    .BURN_TARGET             (burn_target),
    .BURN_MASK               (burn_mask),
    .BURN_VALUE              (burn_value),
    .CONFIG_ONE_REGISTER     (cfg1),
    .CONFIG_TWO_REGISTER     (cfg2),
    .SENSOR_OPTIONS_REGISTER (opts),
    .INTEGRITY_ERROR         (integ_err)
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    if (burn_en === 1'b1)
    begin
      burns <= burns + 1;
      b_tgt <= burn_target;
      b_msk <= burn_mask;
      b_val <= burn_value;
    end
  end

  function automatic logic [3:0] mask_of(input logic [1:0] b,
                                         input logic [3:0] t);
    if (b == BANK_ZERO && t == TGT_LOCK) return 4'h8;
    if (b == BANK_ZERO && t == TGT_FILTER) return 4'hC;
    if (b == BANK_ZERO && t == TGT_IDSEL) return 4'h8;
    if (b == BANK_ONE && t == TGT_ADDR) return 4'hF;
    return 4'h0;
  endfunction : mask_of

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test

  task automatic check_regs;
    `CHK("cfg1", e_c1, cfg1)
    `CHK("cfg2", e_c2, cfg2)
    `CHK("opts", e_op, opts)
  endtask : check_regs

  task automatic do_write(input logic en, input logic [1:0] bank,
                          input logic [3:0] tgt, input logic [3:0] val);
    logic [3:0]  m, a0, nib;
    logic [15:0] exp_r;
    logic        exp_ie;
    int          lat, nb;
    m = mask_of(bank, tgt);
    a0 = e_c2[3:0];
    val = (m == 4'hF && val == 4'h0) ? 4'h3 : val;
    nb = $countones(m & val);
    e_c2[3:0] = (m == 4'hF) ? val : e_c2[3:0];
    e_c2[7] = (m == 4'h8 && tgt == TGT_LOCK) ? val[3] : e_c2[7];
    e_op[7:6] = (m == 4'hC) ? val[3:2] : e_op[7:6];
    e_c1[7] = (m == 4'h8 && tgt == TGT_IDSEL) ? val[3] : e_c1[7];
    nib = (m == 4'hC) ? e_op[7:4] :
          (m == 4'h8 && tgt == TGT_LOCK) ? e_c2[7:4] :
          (m == 4'h8) ? e_c1[7:4] : e_c2[3:0];
    exp_r = en ? {e_c2[3:0], tgt, 2'b11, bank, nib}
               : {e_c2[3:0], 4'h0, 4'hF, e_c2[3:0]};
    @(posedge mclk);
    #1;
    prog_en = en;
    bank_sel = bank;
    crc_stored = $urandom_range(0, 1) ? (e_c1 ^ e_c2 ^ e_op) : 8'($urandom);
    exp_ie = e_c2[7] && ((e_c1 ^ e_c2 ^ e_op) != crc_stored);
    burns = 0;
    u_master.send($urandom_range(0, 1) ? FMT_ENH_LONG : FMT_STD_LONG, 1'b1,
                  {tgt, val, a0, CMD_NIBBLE_WRITE}, $urandom_range(0, 3));
    `CHK("busy_on", 1'b1, busy)
    lat = 0;
    do
    begin
      @(posedge mclk);
      #1;
      lat++;
    end
    while (resp_valid !== 1'b1 && lat < 200);
    `CHK("resp_data", exp_r, resp_data)
    `CHK("latency", en ? nb * BITC + 2 : 1, lat)
    repeat (3) @(posedge mclk);
    #1;
    `CHK("busy", 1'b0, busy)
    check_regs();
    `CHK("integrity", exp_ie, integ_err)
    if (!(en && m != 4'h0 && nb == 0))
      `CHK("burns", (en && nb > 0) ? 1 : 0, burns)
    if (en && nb > 0)
    begin
      `CHK("burn_target", tgt, b_tgt)
      `CHK("burn_mask", m & val, b_msk)
      `CHK("burn_value", val, b_val)
    end
    $display("write done en %0d bank %0d target %h", en, bank, tgt);
  endtask : do_write

  task automatic do_reject(input int k);
    logic [15:0] d;
    onwc_fmt_t   f;
    logic        ok;
    int          n;
    d = {8'($urandom), e_c2[3:0], CMD_NIBBLE_WRITE};
    f = FMT_STD_LONG;
    ok = 1'b1;
    case (k)
      0: f = FMT_STD_SHORT;
      1: f = FMT_ENH_SHORT;
      2: d[7:4] = GLOBAL_ADDR;
      3: d[3:0] = CMD_NIBBLE_WRITE ^ 4'($urandom_range(1, 15));
      4: d[7:4] = e_c2[3:0] ^ 4'($urandom_range(1, 15));
      default: ok = 1'b0;
    endcase
    @(posedge mclk);
    #1;
    prog_en = 1'($urandom);
    bank_sel = 2'($urandom);
    u_master.send(f, ok, d, 0);
    n = 0;
    repeat (12)
    begin
      @(posedge mclk);
      #1;
      n += (resp_valid === 1'b1) ? 1 : 0;
    end
    `CHK("refused_resp", 0, n)
    check_regs();
    $display("reject done kind %0d", k);
  endtask : do_reject

  initial
  begin
    #160000;
    errors++;
    $display("Watchdog expired");
    end_of_test();
  end

  initial
  begin
    void'($urandom(6425));
    rst = 1'b1;
    prog_en = 1'b0;
    bank_sel = 2'h0;
    crc_stored = 8'h00;
    errors = 0;
    total_checks = 0;
    burns = 0;
    e_c1 = CFG1_RST;
    e_c2 = CFG2_RST;
    e_op = OPTS_RST;
    repeat (20) @(posedge mclk);
    #1;
    rst = 1'b0;
    check_regs();
    `CHK("rst_resp", 1'b0, resp_valid)
    `CHK("rst_busy", 1'b0, busy)
    for (int en = 0; en < 2; en++)
    begin
      do_write(en[0], BANK_ZERO, TGT_LOCK, 4'hF);
      do_write(en[0], BANK_ZERO, TGT_FILTER, 4'hE);
      do_write(en[0], BANK_ZERO, TGT_IDSEL, 4'h8);
      do_write(en[0], BANK_ZERO, 4'h9, 4'hF);
      do_write(en[0], BANK_ONE, TGT_ADDR, 4'h5 + en[3:0]);
      do_write(en[0], 2'h3, TGT_ADDR, 4'hA);
      do_write(en[0], BANK_ZERO, TGT_LOCK, 4'h0);
    end
    $display("test corner done, errors %0d", errors);
    for (int k = 0; k < 6; k++)
      do_reject(k);
    $display("test reject done, errors %0d", errors);
    repeat (40)
      do_write(1'($urandom), 2'($urandom), 4'($urandom), 4'($urandom));
    $display("test random done, errors %0d", errors);
    end_of_test();
  end
endmodule : otp_nibble_write_cmd_tb
